// ### include/acrt_regs.svh
// Register indices, field positions and reset values of the result and trigger block.
// Assumes APB byte addressing with one 32-bit word per register (byte address = index * 4).
`ifndef ACRT_REGS_SVH
`define ACRT_REGS_SVH
// Register indices
`define ACRT_I_DID 8'h01
`define ACRT_I_CSRB 8'h03
`define ACRT_I_RESL 8'h04
`define ACRT_I_RESH 8'h05
`define ACRT_I_CTRL 8'h06
`define ACRT_I_STAT 8'h08
`define ACRT_I_MASK 8'h09
// Control/status B fields
`define ACRT_CSRB_BIN 7
`define ACRT_CSRB_CMUX 6
`define ACRT_CSRB_ALIGN 4
`define ACRT_CSRB_TS_HI 2
`define ACRT_CSRB_TS_LO 0
// Own control fields
`define ACRT_CTRL_EN 7
`define ACRT_CTRL_START 6
`define ACRT_CTRL_AUTO 5
// Status and mask fields
`define ACRT_ST_DONE 0
`define ACRT_ST_LOST 1
// Values
`define ACRT_RST8 8'h00
`define ACRT_TS_FREE 3'h0
`define ACRT_RES_FULL 10'h3ff
`endif

// ### include/acrt_pkg.sv
// Types shared by the result and trigger block.
// Assumes a 32-bit APB bus with 8-bit addresses.
package acrt_pkg;
  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } acrt_apb_req_t;
  // APB answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } acrt_apb_rsp_t;
  // Finished conversion from the analog core
  typedef struct packed {
    logic done;
    logic neg;
    logic [9:0] data;
  } acrt_conv_t;
endpackage

// ### core/acrt_top.sv
// Result registers, trigger selection, input disable and interrupt of the converter.
// Assumes one clock, synchronous active-low reset, trigger flags from same-clock
// peripherals, a one-cycle done pulse from the analog core, and raw pins from outside.
//
// Behaviour
// - A finished conversion loads its 10-bit result into the low and high bytes.
// - After a low-byte read, results stay frozen until the high byte is read.
// - Alignment clear: result 9:8 in high bits 1:0, 7:0 in low byte.
// - Alignment set: result 9:2 in high byte, 1:0 in low bits 7:6.
// - Changing alignment changes the byte view at once, even mid-conversion.
// - Unipolar mode gives one-sided results, saturating when positive is not above.
// - Bipolar select bit 7 gives two's complement results, nine bits plus sign.
// - Reserved bits 5 and 3 read back the value last written.
// - Trigger source field acts only while auto-trigger enable is set.
// - Codes: free run, comparator, ext int 0, t0 cmpA, t0 ovf, t1 cmpB, ovf, capture.
// - Auto-trigger starts a conversion on a rising edge of the selected flag.
// - Switching from a clear source to a set source counts as rising edge.
// - Switching to free running never triggers, even with the done flag set.
// - A set disable bit turns off that pin's buffer and reads its input zero.
// - Done flag sets when results update; cleared by writing one or vector entry.
// - With enable and auto-trigger on, each positive edge of the chosen trigger starts conversion.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "acrt_regs.svh"
module acrt_top
  import acrt_pkg::*;
#(
  parameter int NPIN = 8
)
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire acrt_apb_req_t i_apb,
  output acrt_apb_rsp_t o_apb,
  input wire acrt_conv_t i_conv,
  input wire logic [7:0] i_trig_flags,
  input wire logic i_vector_ack,
  input wire logic [NPIN-1:0] i_pin,
  output logic [NPIN-1:0] o_pin_in,
  output logic [NPIN-1:0] o_pin_buf_off,
  output logic o_conv_start,
  output logic o_bipolar,
  output logic o_cmp_mux_en,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] csrb;
  logic [7:0] did;
  logic conv_en;
  logic auto_en;
  logic [1:0] stat;
  logic [1:0] mask;
  logic [9:0] result;
  logic locked;
  logic prev_src;
  logic [2:0] prev_ts;
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic acc;
  logic done;
  logic wr;
  logic rd;
  logic sel_did;
  logic sel_csrb;
  logic sel_resl;
  logic sel_resh;
  logic sel_ctrl;
  logic sel_stat;
  logic sel_mask;
  logic hit;
  logic [7:0] view_l;
  logic [7:0] view_h;
  logic [7:0] rd_byte;
  logic [2:0] ts;
  logic align;
  logic cur_src;
  logic trig_edge;
  logic load;
  logic [9:0] next_result;
  logic man_start;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign acc = i_apb.psel & i_apb.penable;
  assign done = acc & o_apb.pready;
  assign wr = done & i_apb.pwrite;
  assign rd = done & ~i_apb.pwrite;
  assign sel_did = (i_apb.paddr == (`ACRT_I_DID << 2));
  assign sel_csrb = (i_apb.paddr == (`ACRT_I_CSRB << 2));
  assign sel_resl = (i_apb.paddr == (`ACRT_I_RESL << 2));
  assign sel_resh = (i_apb.paddr == (`ACRT_I_RESH << 2));
  assign sel_ctrl = (i_apb.paddr == (`ACRT_I_CTRL << 2));
  assign sel_stat = (i_apb.paddr == (`ACRT_I_STAT << 2));
  assign sel_mask = (i_apb.paddr == (`ACRT_I_MASK << 2));
  assign hit = sel_did | sel_csrb | sel_resl | sel_resh | sel_ctrl | sel_stat | sel_mask;

  // Field views
  assign ts = csrb[`ACRT_CSRB_TS_HI:`ACRT_CSRB_TS_LO];
  assign align = csrb[`ACRT_CSRB_ALIGN];

  // Byte views follow alignment live, unused bits zero
  always_comb
  begin
    if (align)
    begin
      view_h = result[9:2];
      view_l = {result[1:0], 6'h00};
    end
    else
    begin
      view_h = {6'h00, result[9:8]};
      view_l = result[7:0];
    end
  end

  // Read data mux
  always_comb
  begin
    rd_byte = `ACRT_RST8;
    if (sel_did)
      rd_byte = did;
    if (sel_csrb)
      rd_byte = csrb;
    if (sel_resl)
      rd_byte = view_l;
    if (sel_resh)
      rd_byte = view_h;
    if (sel_ctrl)
      rd_byte = {conv_en, 1'b0, auto_en, 5'h00};
    if (sel_stat)
      rd_byte = {6'h00, stat};
    if (sel_mask)
      rd_byte = {6'h00, mask};
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: pready one cycle into access, data and error latched with it
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
      o_apb <= '0;
    else if (i_ce)
    begin
      o_apb.pready <= acc & ~o_apb.pready;
      if (acc & ~o_apb.pready)
      begin
        o_apb.prdata <= {24'h000000, rd_byte};
        o_apb.pslverr <= ~hit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      csrb <= `ACRT_RST8;
      did <= `ACRT_RST8;
      conv_en <= 1'b0;
      auto_en <= 1'b0;
      mask <= 2'h0;
    end
    else if (i_ce && wr)
    begin
      if (sel_csrb)
        csrb <= i_apb.pwdata[7:0];
      if (sel_did)
        did <= i_apb.pwdata[7:0];
      if (sel_ctrl)
      begin
        conv_en <= i_apb.pwdata[`ACRT_CTRL_EN];
        auto_en <= i_apb.pwdata[`ACRT_CTRL_AUTO];
      end
      if (sel_mask)
        mask <= i_apb.pwdata[1:0];
    end
  end

  // Mode outputs
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      o_bipolar <= 1'b0;
      o_cmp_mux_en <= 1'b0;
    end
    else if (i_ce)
    begin
      o_bipolar <= csrb[`ACRT_CSRB_BIN];
      o_cmp_mux_en <= csrb[`ACRT_CSRB_CMUX];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result capture and read lock
  assign load = i_conv.done & ~locked;
  always_comb
  begin
    if (!csrb[`ACRT_CSRB_BIN] && i_conv.neg)
      next_result = `ACRT_RES_FULL;
    else
      next_result = i_conv.data;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
      result <= 10'h000;
    else if (i_ce && load)
      result <= next_result;
  end

  // Lock set by low-byte read, released by high-byte read
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
      locked <= 1'b0;
    else if (i_ce)
    begin
      if (rd && sel_resh)
        locked <= 1'b0;
      else if (rd && sel_resl)
        locked <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, set wins over write-one clear and vector entry
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
      stat <= 2'h0;
    else if (i_ce)
    begin
      if (load)
        stat[`ACRT_ST_DONE] <= 1'b1;
      else if ((wr && sel_stat && i_apb.pwdata[`ACRT_ST_DONE]) || i_vector_ack)
        stat[`ACRT_ST_DONE] <= 1'b0;
      if (i_conv.done && locked)
        stat[`ACRT_ST_LOST] <= 1'b1;
      else if (wr && sel_stat && i_apb.pwdata[`ACRT_ST_LOST])
        stat[`ACRT_ST_LOST] <= 1'b0;
    end
  end

  // Interrupt level
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
      o_irq <= 1'b0;
    else if (i_ce)
      o_irq <= |(stat & mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger source and edge detection
  always_comb
  begin
    if (ts == `ACRT_TS_FREE)
      cur_src = stat[`ACRT_ST_DONE];
    else
      cur_src = i_trig_flags[ts];
  end
  // Switching into free running is never an edge
  assign trig_edge = cur_src & ~prev_src
    & ~((ts == `ACRT_TS_FREE) && (prev_ts != `ACRT_TS_FREE));
  assign man_start = wr & sel_ctrl & i_apb.pwdata[`ACRT_CTRL_START]
    & i_apb.pwdata[`ACRT_CTRL_EN];

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      prev_src <= 1'b0;
      prev_ts <= `ACRT_TS_FREE;
    end
    else if (i_ce)
    begin
      prev_src <= cur_src;
      prev_ts <= ts;
    end
  end

  // Conversion start pulse
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
      o_conv_start <= 1'b0;
    else if (i_ce)
      o_conv_start <= man_start
        | (conv_en & auto_en & trig_edge);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and input disable
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end
    else if (i_ce)
    begin
      pin_s1 <= i_pin;
      pin_s2 <= pin_s1;
    end
  end

  // Per-pin gating
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_pin
      always_ff @(posedge i_clk)
      begin
        if (!i_rst_b)
        begin
          o_pin_in[gi] <= 1'b0;
          o_pin_buf_off[gi] <= 1'b0;
        end
        else if (i_ce)
        begin
          o_pin_in[gi] <= pin_s2[gi] & ~did[gi];
          o_pin_buf_off[gi] <= did[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  lock_hold_a: assert property (i_ce && locked && !(rd && sel_resh) |=> $stable(result))
    else $error("result changed while locked");
  load_res_a: assert property (i_ce && load |=> result == $past(next_result))
    else $error("result not loaded");
  sat_uni_a: assert property (i_ce && load && !csrb[`ACRT_CSRB_BIN] && i_conv.neg
    |=> result == `ACRT_RES_FULL)
    else $error("unipolar result not saturated");
  right_view_a: assert property (i_ce && acc && !o_apb.pready && !align && sel_resh
    |=> o_apb.prdata == {30'h0, $past(result[9:8])})
    else $error("right view wrong");
  left_view_a: assert property (i_ce && acc && !o_apb.pready && align && sel_resl
    |=> o_apb.prdata == {24'h0, $past(result[1:0]), 6'h00})
    else $error("left view wrong");
  free_notrig_a: assert property (i_ce && ts == `ACRT_TS_FREE
    && prev_ts != `ACRT_TS_FREE && !man_start |=> !o_conv_start)
    else $error("free running switch triggered");
  auto_trig_a: assert property (i_ce && conv_en && auto_en && trig_edge |=> o_conv_start)
    else $error("trigger edge missed");
  no_auto_a: assert property (i_ce && !auto_en && !man_start |=> !o_conv_start)
    else $error("start without auto trigger");
  done_flag_a: assert property (i_ce && load |=> stat[0] [*1] ##0 result == $past(next_result))
    else $error("done flag not set");
  pin_off_a: assert property (i_ce |=> (o_pin_in & $past(did)) == '0)
    else $error("disabled pin reads one");
  res_bits_a: assert property (i_ce && wr && sel_csrb |=> csrb[5] == $past(i_apb.pwdata[5])
    && csrb[3] == $past(i_apb.pwdata[3]))
    else $error("reserved bits not stored");

  lock_seen_c: cover property (locked ##1 (i_conv.done && locked));
  auto_start_c: cover property (auto_en && trig_edge ##1 o_conv_start);
  left_read_c: cover property (align && rd && sel_resh);
  irq_c: cover property (!o_irq ##1 o_irq);

endmodule

// ### tb/acrt_top_bench.sv
// Self-checking bench for the converter result, trigger and input disable block.
// Assumes acrt_top with APB at byte address = index * 4 and a one-cycle done pulse.
`timescale 1ns/1ps
`include "acrt_regs.svh"
module acrt_top_bench
  import acrt_pkg::*;
;
  logic i_clk;
  logic i_rst_b;
  logic ce;
  acrt_apb_req_t req;
  acrt_apb_rsp_t o_apb;
  acrt_conv_t conv;
  logic [7:0] flags;
  logic ack;
  logic [7:0] pins;
  logic [7:0] pin_in;
  logic [7:0] buf_off;
  logic start;
  logic bipolar;
  logic cmux;
  logic irq;
  int n_errors;
  int n_tests;
  int n_starts;
  int n0;
  logic [31:0] rdat;
  logic serr;

  ////////////////////////////////////////////////////////////////////////////
  // Device under test, all inputs driven
  acrt_top #(.NPIN(8)) uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(ce), .i_apb(req),
    .o_apb(o_apb), .i_conv(conv), .i_trig_flags(flags), .i_vector_ack(ack), .i_pin(pins),
    .o_pin_in(pin_in), .o_pin_buf_off(buf_off), .o_conv_start(start), .o_bipolar(bipolar),
    .o_cmp_mux_en(cmux), .o_irq(irq));

  // Clock, 40 ns period
  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Count conversion start pulses
  always @(posedge i_clk)
    if (start === 1'b1)
      n_starts++;

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int k;
    @(posedge i_clk);
    req <= '{1'b1, 1'b0, w, idx << 2, wd};
    @(posedge i_clk);
    req.penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge i_clk);
      if (o_apb.pready === 1'b1)
        break;
    end
    if (k == 20)
    begin
      n_errors++;
      summarize();
    end
    rdat = o_apb.prdata;
    serr = o_apb.pslverr;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rdat, exp);
  endtask

  task automatic cv(input logic [9:0] d, input logic neg);
    @(posedge i_clk);
    conv <= '{1'b1, neg, d};
    @(posedge i_clk);
    conv <= '0;
    @(posedge i_clk);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    rdc(`ACRT_I_RESL, 32'h0);
    rdc(`ACRT_I_RESH, 32'h0);
    rdc(`ACRT_I_CSRB, 32'h0);
    wr(`ACRT_I_CSRB, 32'h28);
    rdc(`ACRT_I_CSRB, 32'h28);
    wr(`ACRT_I_CSRB, 32'hc0);
    idle(2);
    chk({cmux, bipolar}, 32'h3);
    apb(1'b0, 8'h3f, 32'h0);
    chk(serr, 32'h1);
    chk(rdat, 32'h0);
    wr(`ACRT_I_CSRB, 32'h0);
    $display("done t_regs");
  endtask

  task automatic t_pins();
    wr(`ACRT_I_DID, 32'h0f);
    rdc(`ACRT_I_DID, 32'h0f);
    pins <= 8'hff;
    idle(5);
    chk(pin_in, 32'hf0);
    chk(buf_off, 32'h0f);
    $display("done t_pins");
  endtask

  task automatic t_align();
    wr(`ACRT_I_MASK, 32'h1);
    cv(10'h2d5, 1'b0);
    idle(1);
    chk(irq, 32'h1);
    rdc(`ACRT_I_RESL, 32'hd5);
    rdc(`ACRT_I_RESH, 32'h02);
    wr(`ACRT_I_CSRB, 32'h10);
    rdc(`ACRT_I_RESL, 32'h40);
    rdc(`ACRT_I_RESH, 32'hb5);
    cv(10'h0ff, 1'b0);
    rdc(`ACRT_I_RESH, 32'h3f);
    cv(10'h300, 1'b0);
    rdc(`ACRT_I_RESH, 32'hc0);
    wr(`ACRT_I_STAT, 32'h1);
    idle(2);
    chk(irq, 32'h0);
    wr(`ACRT_I_MASK, 32'h0);
    cv(10'h2d5, 1'b0);
    idle(2);
    chk(irq, 32'h0);
    ack <= 1'b1;
    @(posedge i_clk);
    ack <= 1'b0;
    rdc(`ACRT_I_STAT, 32'h0);
    wr(`ACRT_I_CSRB, 32'h0);
    $display("done t_align");
  endtask

  task automatic t_lock();
    cv(10'h155, 1'b0);
    wr(`ACRT_I_STAT, 32'h3);
    rdc(`ACRT_I_RESL, 32'h55);
    cv(10'h2aa, 1'b0);
    rdc(`ACRT_I_RESH, 32'h01);
    rdc(`ACRT_I_STAT, 32'h2);
    cv(10'h2aa, 1'b0);
    rdc(`ACRT_I_RESL, 32'haa);
    rdc(`ACRT_I_RESH, 32'h02);
    cv(10'h123, 1'b1);
    rdc(`ACRT_I_RESL, 32'hff);
    rdc(`ACRT_I_RESH, 32'h03);
    wr(`ACRT_I_CSRB, 32'h80);
    cv(10'h3f0, 1'b1);
    rdc(`ACRT_I_RESL, 32'hf0);
    rdc(`ACRT_I_RESH, 32'h03);
    wr(`ACRT_I_CSRB, 32'h0);
    $display("done t_lock");
  endtask

  task automatic t_trig();
    wr(`ACRT_I_CTRL, 32'ha0);
    for (int c = 1; c < 8; c++)
    begin
      wr(`ACRT_I_CSRB, c);
      flags <= 8'h0;
      idle(2);
      n0 = n_starts;
      flags <= 8'h1 << c;
      idle(4);
      chk(n_starts - n0, 32'h1);
    end
    wr(`ACRT_I_CTRL, 32'h80);
    wr(`ACRT_I_CSRB, 32'h3);
    flags <= 8'h0;
    idle(2);
    n0 = n_starts;
    flags <= 8'h08;
    idle(4);
    chk(n_starts - n0, 32'h0);
    wr(`ACRT_I_CTRL, 32'ha0);
    wr(`ACRT_I_CSRB, 32'h1);
    flags <= 8'h04;
    idle(2);
    n0 = n_starts;
    wr(`ACRT_I_CSRB, 32'h2);
    idle(3);
    chk(n_starts - n0, 32'h1);
    flags <= 8'h0;
    wr(`ACRT_I_STAT, 32'h3);
    cv(10'h0, 1'b0);
    n0 = n_starts;
    wr(`ACRT_I_CSRB, 32'h0);
    idle(3);
    chk(n_starts - n0, 32'h0);
    wr(`ACRT_I_STAT, 32'h1);
    n0 = n_starts;
    cv(10'h0, 1'b0);
    idle(3);
    chk(n_starts - n0, 32'h1);
    wr(`ACRT_I_CTRL, 32'h80);
    n0 = n_starts;
    wr(`ACRT_I_CTRL, 32'hc0);
    idle(3);
    chk(n_starts - n0, 32'h1);
    $display("done t_trig");
  endtask

  // Clock enable freeze, then reset in mid-run clears results and status
  task automatic t_reset();
    ce <= 1'b0;
    cv(10'h3aa, 1'b0);
    ce <= 1'b1;
    rdc(`ACRT_I_RESL, 32'h0);
    rdc(`ACRT_I_RESH, 32'h0);
    cv(10'h3aa, 1'b0);
    i_rst_b <= 1'b0;
    idle(2);
    i_rst_b <= 1'b1;
    rdc(`ACRT_I_RESL, 32'h0);
    rdc(`ACRT_I_RESH, 32'h0);
    rdc(`ACRT_I_STAT, 32'h0);
    $display("done t_reset");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    n_errors = 0;
    n_tests = 0;
    n_starts = 0;
    i_rst_b = 1'b0;
    ce = 1'b1;
    req = '0;
    conv = '0;
    flags = 8'h0;
    ack = 1'b0;
    pins = 8'h0;
    idle(2);
    i_rst_b <= 1'b1;
    t_regs();
    t_pins();
    t_align();
    t_lock();
    t_trig();
    t_reset();
    summarize();
  end
endmodule
